// ---- verilog/arseq_pkg.sv ----
// shared constants and carriers of the auto-reclose sequencer
package arseq_pkg;
  localparam int unsigned CLK_NS = 25;
  localparam int unsigned TICK_MS = 10;
  localparam int unsigned TICK_CYC = TICK_MS * 1000000 / CLK_NS;
  localparam int unsigned FINAL_TRIP_MS = 500;
  localparam logic [5:0] TRIP_HOLD_TICKS = 6'(FINAL_TRIP_MS / TICK_MS);
  localparam int unsigned NUM_SHOTS = 5;
  localparam int unsigned NUM_LINES = 4;
  localparam int unsigned TW = 16;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LINE_EN = 8'h04;
  localparam logic [7:0] ADDR_COMMON_RECLAIM = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [2:0] BANK_MISC = 3'h0;
  localparam logic [2:0] BANK_DEAD = 3'h1;
  localparam logic [2:0] BANK_DISCR = 3'h2;
  localparam logic [2:0] BANK_RECLAIM = 3'h3;
  localparam logic [2:0] START_DLY_IDX0 = 3'h4;

  localparam int unsigned CTRL_ENABLE = 0;
  localparam int unsigned CTRL_SHOT_RECLAIM = 1;
  localparam int unsigned CTRL_AUTO_BRK = 2;
  localparam int unsigned CTRL_FIRST_OBJ = 4;
  localparam int unsigned CTRL_SECOND_OBJ = 8;
  localparam logic [11:0] CTRL_RESET = 12'h100;
  localparam logic [1:0] CRIT_LINE = 2'h0;

  typedef enum logic [2:0] {
    ST_READY = 3'b000,
    ST_OPEN = 3'b001,
    ST_DEAD = 3'b011,
    ST_CLOSE = 3'b010,
    ST_DISCR = 3'b110,
    ST_RECLAIM = 3'b111,
    ST_LOCKED = 3'b101,
    ST_SPARE = 3'b100
  } arseq_state_type;

  typedef struct packed {
    logic [3:0] request_line;
    logic critical_request;
    logic first_breaker_closed;
    logic second_breaker_closed;
    logic manual_close;
    logic manual_open;
    logic control_fail;
    logic external_control;
    logic alternate_breaker_select_input;
    logic [4:0] shot_block;
  } arseq_pins_type;
endpackage : arseq_pkg

// ---- verilog/arseq_sync.sv ----
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module arseq_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      // a bit only moves once two settled stages agree
      q <= (s2 & s3) | (q & (s2 | s3));
    end
  end
endmodule : arseq_sync

// ---- verilog/arseq_tick.sv ----
// fixed-period tick from the system clock
`timescale 1ns/1ps
module arseq_tick #(
  parameter int unsigned DIV = 400000
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);
  localparam int unsigned CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] cnt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (cnt == LAST);
      cnt <= (cnt == LAST) ? '0 : cnt + 1'b1;
    end
  end
endmodule : arseq_tick

// ---- verilog/arseq_top.sv ----
// auto-reclose sequencer with its apb register file
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module arseq_top
  import arseq_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input arseq_pins_type pins,
  output logic open_cmd,
  output logic close_cmd,
  output logic [3:0] ctrl_object,
  output logic [4:0] final_trip,
  output logic dead_running,
  output logic [4:0] shot_active
);
  arseq_pins_type sp;
  logic [$bits(arseq_pins_type)-1:0] sync_q;
  logic tick;
  logic [11:0] ctrl;
  logic [19:0] line_en;
  logic [TW-1:0] common_recl;
  logic [TW-1:0] start_dly [NUM_LINES];
  logic [TW-1:0] dead_t [NUM_SHOTS];
  logic [TW-1:0] discr_t [NUM_SHOTS];
  logic [TW-1:0] recl_t [NUM_SHOTS];
  arseq_state_type state;
  logic [2:0] shot;
  logic manual_recl;
  logic [TW-1:0] tcnt;
  logic ft_evt;
  logic [2:0] ft_line;
  logic [5:0] hold_cnt;
  logic [7:0] success_cnt;
  logic sel_second;
  logic last_second;
  logic prev_mclose;
  logic prev_mopen;
  logic [NUM_LINES-1:0] expired;
  logic enable;
  logic brk_closed;
  logic seq_run;
  logic man_close_evt;
  logic man_open_evt;
  logic crit_ok;
  logic req_any;
  logic [1:0] win;
  logic win_valid;
  logic [1:0] hp;
  logic [3:0] fs;
  logic [3:0] ns;
  logic [TW-1:0] recl_val;
  logic acc;
  logic [2:0] bank;
  logic [2:0] idx;
  logic mapped;
  logic [31:0] rd_val;

  arseq_sync #(.W($bits(arseq_pins_type))) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(pins),
    .q(sync_q)
  );
  assign sp = arseq_pins_type'(sync_q);

  arseq_tick #(.DIV(TICK_DIV)) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick)
  );

  // first unblocked shot at or after 'from' enabled for 'line'; bit 3 = found
  function automatic logic [3:0] find_shot(input logic [2:0] from,
      input logic [1:0] line, input logic [19:0] en, input logic [4:0] blk);
    logic [3:0] r;
    r = 4'h0;
    for (int s = NUM_SHOTS - 1; s >= 0; s--) begin
      if (s >= int'(from) && !blk[s] && en[s*4 + int'(line)]) begin
        r = {1'b1, 3'(s)};
      end
    end
    return r;
  endfunction : find_shot

  assign enable = ctrl[CTRL_ENABLE];
  assign brk_closed = sel_second ? sp.second_breaker_closed
                                 : sp.first_breaker_closed;
  assign seq_run = (state != ST_READY) && (state != ST_LOCKED) && !manual_recl;
  assign man_close_evt = sp.manual_close && !prev_mclose;
  assign man_open_evt = sp.manual_open && !prev_mopen;
  assign crit_ok = sp.critical_request && seq_run &&
                   (state == ST_DEAD || state == ST_DISCR);
  assign req_any = |sp.request_line;

  always_comb begin
    hp = 2'h0;
    win = 2'h0;
    win_valid = 1'b0;
    for (int i = NUM_LINES - 1; i >= 0; i--) begin
      if (sp.request_line[i]) begin
        hp = 2'(i);
      end
      if (expired[i]) begin
        win = 2'(i);
        win_valid = 1'b1;
      end
    end
  end

  assign fs = find_shot(3'h0, win, line_en, sp.shot_block);
  assign ns = find_shot(3'(shot + 3'h1), hp, line_en, sp.shot_block);
  assign recl_val = (manual_recl || !ctrl[CTRL_SHOT_RECLAIM]) ? common_recl
                    : recl_t[shot];

  // per-line start-delay counters, armed only while ready
  generate
    for (genvar g = 0; g < NUM_LINES; g++) begin : g_start
      logic [TW-1:0] cnt;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          cnt <= '0;
        end else if (!(enable && state == ST_READY && sp.request_line[g])) begin
          cnt <= '0;
        end else if (tick && cnt < start_dly[g]) begin
          cnt <= cnt + 1'b1;
        end
      end
      assign expired[g] = enable && state == ST_READY &&
                          sp.request_line[g] && cnt >= start_dly[g];
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_mclose <= 1'b0;
      prev_mopen <= 1'b0;
    end else begin
      prev_mclose <= sp.manual_close;
      prev_mopen <= sp.manual_open;
    end
  end

  // sequence engine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_READY;
      shot <= 3'h0;
      manual_recl <= 1'b0;
      tcnt <= '0;
      open_cmd <= 1'b0;
      close_cmd <= 1'b0;
      ft_evt <= 1'b0;
      ft_line <= 3'h0;
      success_cnt <= 8'h00;
      dead_running <= 1'b0;
    end else begin
      ft_evt <= 1'b0;
      // follows the next state, so it falls with the close command
      dead_running <= 1'b0;
      if (tick && tcnt != '0) begin
        tcnt <= tcnt - 1'b1;
      end
      if (man_close_evt) begin
        state <= ST_RECLAIM;
        manual_recl <= 1'b1;
        tcnt <= common_recl;
        shot <= 3'h0;
        open_cmd <= 1'b0;
        close_cmd <= 1'b0;
      end else if (!enable ||
          (seq_run && (man_open_evt || sp.control_fail ||
                       sp.external_control))) begin
        // stop without touching the breaker again
        state <= (state == ST_LOCKED && enable) ? ST_LOCKED : ST_READY;
        shot <= 3'h0;
        manual_recl <= 1'b0;
        open_cmd <= 1'b0;
        close_cmd <= 1'b0;
      end else if (crit_ok) begin
        state <= ST_LOCKED;
        open_cmd <= 1'b1;
        close_cmd <= 1'b0;
        ft_evt <= 1'b1;
        ft_line <= {1'b1, CRIT_LINE};
      end else begin
        unique case (state)
          ST_READY: begin
            if (win_valid) begin
              if (fs[3]) begin
                shot <= fs[2:0];
                state <= ST_OPEN;
                open_cmd <= 1'b1;
              end else begin
                state <= ST_LOCKED;
                open_cmd <= 1'b1;
                ft_evt <= 1'b1;
                ft_line <= {1'b0, win};
              end
            end
          end
          ST_OPEN: begin
            if (!brk_closed) begin
              open_cmd <= 1'b0;
              state <= ST_DEAD;
              dead_running <= 1'b1;
              tcnt <= dead_t[shot];
            end
          end
          ST_DEAD: begin
            if (tcnt == '0) begin
              close_cmd <= 1'b1;
              state <= ST_CLOSE;
            end else begin
              dead_running <= 1'b1;
            end
          end
          ST_CLOSE: begin
            if (brk_closed) begin
              close_cmd <= 1'b0;
              state <= ST_DISCR;
              tcnt <= discr_t[shot];
            end
          end
          ST_DISCR, ST_RECLAIM: begin
            if (req_any && !manual_recl) begin
              open_cmd <= 1'b1;
              if (ns[3]) begin
                shot <= ns[2:0];
                state <= ST_OPEN;
              end else begin
                state <= ST_LOCKED;
                ft_evt <= 1'b1;
                ft_line <= {1'b0, hp};
              end
            end else if (tcnt == '0) begin
              if (state == ST_DISCR) begin
                state <= ST_RECLAIM;
                tcnt <= recl_val;
              end else begin
                state <= ST_READY;
                shot <= 3'h0;
                manual_recl <= 1'b0;
                if (!manual_recl) begin
                  success_cnt <= success_cnt + 8'h01;
                end
              end
            end
          end
          ST_LOCKED: begin
            if (!brk_closed) begin
              open_cmd <= 1'b0;
            end
          end
          ST_SPARE: begin
            state <= ST_READY;
          end
        endcase
      end
    end
  end

  // final-trip flag held for a fixed time, then self-clearing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      final_trip <= 5'h00;
      hold_cnt <= 6'h00;
    end else if (ft_evt) begin
      final_trip <= 5'(5'h01 << ft_line);
      hold_cnt <= TRIP_HOLD_TICKS;
    end else if (tick && hold_cnt != 6'h00) begin
      hold_cnt <= hold_cnt - 6'h01;
      if (hold_cnt == 6'h01) begin
        final_trip <= 5'h00;
      end
    end
  end

  // breaker steering
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_second <= 1'b0;
      last_second <= 1'b0;
      ctrl_object <= 4'h0;
    end else begin
      if (sp.second_breaker_closed && !sp.first_breaker_closed) begin
        last_second <= 1'b1;
      end else if (sp.first_breaker_closed && !sp.second_breaker_closed) begin
        last_second <= 1'b0;
      end
      if (!brk_closed) begin
        sel_second <= ctrl[CTRL_AUTO_BRK] ? last_second
                      : sp.alternate_breaker_select_input;
      end
      ctrl_object <= sel_second ? ctrl[CTRL_SECOND_OBJ +: 4]
                     : {1'b0, ctrl[CTRL_FIRST_OBJ +: 3]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shot_active <= 5'h00;
    end else begin
      shot_active <= seq_run ? 5'(5'h01 << shot) : 5'h00;
    end
  end

  // apb slave: one wait state, then answer
  assign acc = psel && penable && pready;
  assign bank = paddr[7:5];
  assign idx = paddr[4:2];

  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (bank)
      BANK_MISC: begin
        if (idx >= START_DLY_IDX0) begin
          rd_val = {16'h0000, start_dly[2'(idx - START_DLY_IDX0)]};
        end else if ({paddr[7:2], 2'b00} == ADDR_CTRL) begin
          rd_val = {20'h00000, ctrl};
        end else if ({paddr[7:2], 2'b00} == ADDR_LINE_EN) begin
          rd_val = {12'h000, line_en};
        end else if ({paddr[7:2], 2'b00} == ADDR_COMMON_RECLAIM) begin
          rd_val = {16'h0000, common_recl};
        end else begin
          rd_val = {success_cnt, 3'h0, sel_second, 3'h0, final_trip,
                    1'b0, state == ST_LOCKED, seq_run, state == ST_READY,
                    1'b0, shot + 3'h1, 1'b0, state};
        end
      end
      BANK_DEAD, BANK_DISCR, BANK_RECLAIM: begin
        if (idx < 3'(NUM_SHOTS)) begin
          rd_val = {16'h0000, bank == BANK_DEAD ? dead_t[idx]
                    : bank == BANK_DISCR ? discr_t[idx] : recl_t[idx]};
        end else begin
          mapped = 1'b0;
        end
      end
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      prdata <= (psel && penable && !pready && !pwrite && mapped) ? rd_val
                : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= CTRL_RESET;
      line_en <= 20'h00000;
      common_recl <= '0;
      for (int i = 0; i < NUM_LINES; i++) begin
        start_dly[i] <= '0;
      end
      for (int i = 0; i < NUM_SHOTS; i++) begin
        dead_t[i] <= '0;
        discr_t[i] <= '0;
        recl_t[i] <= '0;
      end
    end else if (acc && pwrite && mapped) begin
      unique case (bank)
        BANK_MISC: begin
          if (idx >= START_DLY_IDX0) begin
            start_dly[2'(idx - START_DLY_IDX0)] <= pwdata[TW-1:0];
          end else if ({paddr[7:2], 2'b00} == ADDR_CTRL) begin
            ctrl <= pwdata[11:0];
          end else if ({paddr[7:2], 2'b00} == ADDR_LINE_EN) begin
            line_en <= pwdata[19:0];
          end else if ({paddr[7:2], 2'b00} == ADDR_COMMON_RECLAIM) begin
            common_recl <= pwdata[TW-1:0];
          end
        end
        BANK_DEAD: dead_t[idx] <= pwdata[TW-1:0];
        BANK_DISCR: discr_t[idx] <= pwdata[TW-1:0];
        BANK_RECLAIM: recl_t[idx] <= pwdata[TW-1:0];
        default: ;
      endcase
    end
  end
endmodule : arseq_top

// ---- verif/arseq_chk.sv ----
// port assertions for the sequencer
`timescale 1ns/1ps
module arseq_chk
  import arseq_pkg::*;
#(
  parameter int unsigned TICK_DIV = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic open_cmd,
  input wire logic close_cmd,
  input wire logic dead_running,
  input wire logic [4:0] shot_active,
  input wire logic [4:0] final_trip
);
  // tick phase is unknown, so allow a tick of slack each side
  localparam int HOLD_MIN = 49 * TICK_DIV - 8;
  localparam int CLR_MIN = 49 * TICK_DIV;
  localparam int CLR_MAX = 51 * TICK_DIV + 8;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer not after one wait");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_cmd_exclusive: assert property (!(open_cmd && close_cmd))
    else $error("open and close together");
  a_dead_quiet: assert property (dead_running |-> !open_cmd && !close_cmd)
    else $error("command during dead time");
  a_shot_onehot: assert property ($onehot0(shot_active))
    else $error("more than one shot active");
  a_trip_onehot: assert property ($onehot0(final_trip))
    else $error("more than one final trip");
  a_trip_holds: assert property ($rose(|final_trip) |-> ##HOLD_MIN (|final_trip))
    else $error("final trip cleared early");
  a_trip_clears: assert property
    ($rose(|final_trip) |-> ##[CLR_MIN:CLR_MAX] (final_trip == 5'h00))
    else $error("final trip not cleared");
  cover property ($rose(dead_running));
  cover property ($rose(final_trip[4]));
  cover property (pslverr);
endmodule : arseq_chk

// ---- verif/arseq_breaker.sv ----
// breaker model answering open and close commands after a delay
`timescale 1ns/1ps
module arseq_breaker
  import arseq_pkg::*;
#(
  parameter int unsigned DLY = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic open_cmd,
  input wire logic close_cmd,
  input wire logic [3:0] ctrl_object,
  input wire logic man_close,
  output logic first_closed,
  output logic second_closed
);
  logic [3:0] cnt;
  logic [1:0] st;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      st <= 2'h1;
    end else if (man_close) begin
      st[0] <= 1'b1;
    end else if (open_cmd || close_cmd) begin
      cnt <= cnt + 4'h1;
      // mechanism takes a few clocks, never answers at once
      if (cnt == DLY[3:0]) begin
        st[ctrl_object[0]] <= close_cmd;
        cnt <= 4'h0;
      end
    end else begin
      cnt <= 4'h0;
    end
  end
  assign first_closed = st[0];
  assign second_closed = st[1];
endmodule : arseq_breaker

// ---- verif/arseq_top_bench.sv ----
// self-checking bench of the auto-reclose sequencer
`timescale 1ns/1ps
module arseq_top_bench
  import arseq_pkg::*;
();
  localparam int unsigned TD = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, open_cmd, close_cmd, dead_running, b1, b2;
  logic [3:0] ctrl_object;
  logic [4:0] final_trip, shot_active;
  arseq_pins_type drv = '0;
  arseq_pins_type pins;
  int failures = 0;
  int checks_done = 0;
  always #12.5 clk = ~clk;
  always_comb begin
    pins = drv;
    pins.first_breaker_closed = b1;
    pins.second_breaker_closed = b2;
  end
  arseq_top #(.TICK_DIV(TD)) uut (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .open_cmd(open_cmd), .close_cmd(close_cmd), .ctrl_object(ctrl_object),
    .final_trip(final_trip), .dead_running(dead_running),
    .shot_active(shot_active));
  arseq_breaker brk (.clk(clk), .rst_n(rst_n), .open_cmd(open_cmd),
    .close_cmd(close_cmd), .ctrl_object(ctrl_object),
    .man_close(drv.manual_close), .first_closed(b1), .second_closed(b2));
  task automatic final_report();
    if (failures == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    penable <= 1'b0;
    psel <= 1'b0;
    if (n >= 16) begin
      failures++;
      final_report();
    end
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask : rd
  function automatic logic [4:0] pick(input int s);
    case (s)
      0: return {4'h0, open_cmd};
      1: return {4'h0, close_cmd};
      2: return {4'h0, dead_running};
      3: return shot_active;
      default: return final_trip;
    endcase
  endfunction : pick
  task automatic waitv(input int s, input logic [4:0] v);
    int n;
    n = 0;
    while (pick(s) !== v && n < 600) begin
      @(posedge clk);
      n++;
    end
    chk("output", {27'h0, v}, {27'h0, pick(s)});
    if (n >= 600) begin
      failures++;
      final_report();
    end
  endtask : waitv
  task automatic wait_state(input logic [2:0] v);
    logic [31:0] r;
    int n;
    n = 0;
    do begin
      rd(ADDR_STATUS, r);
      n++;
    end while (r[2:0] !== v && n < 200);
    chk("state", {29'h0, v}, {29'h0, r[2:0]});
    if (n >= 200) begin
      failures++;
      final_report();
    end
  endtask : wait_state
  task automatic setup(input logic [31:0] en);
    wr(ADDR_CTRL, 32'h101);
    wr(ADDR_LINE_EN, en);
    wr(ADDR_COMMON_RECLAIM, 32'h1E);
    for (int i = 0; i < 5; i++) begin
      if (i < 4)
        wr(8'h10 + 8'(i * 4), 32'h2);
      wr(8'h20 + 8'(i * 4), 32'h3);
      wr(8'h40 + 8'(i * 4), 32'hA);
      wr(8'h60 + 8'(i * 4), 32'h5);
    end
  endtask : setup
  task automatic mclose();
    drv.manual_close <= 1'b1;
    repeat (8) @(posedge clk);
    drv.manual_close <= 1'b0;
  endtask : mclose
  task automatic s_regs();
    logic [31:0] r;
    logic e;
    rd(ADDR_CTRL, r);
    chk("ctrl", 32'h100, r);
    apb(1'b0, 8'h80, 32'h0, r, e);
    chk("slverr", 32'h1, {31'h0, e});
    chk("bad_data", 32'h0, r);
    rd(ADDR_STATUS, r);
    chk("ready", 32'h1, {29'h0, r[10:8]});
  endtask : s_regs
  task automatic s_seq();
    logic [31:0] r;
    setup(32'h11);
    chk("object", 32'h0, {28'h0, ctrl_object});
    drv.request_line <= 4'h1;
    waitv(0, 5'h01);
    waitv(2, 5'h01);
    chk("shot", 32'h1, {27'h0, shot_active});
    waitv(1, 5'h01);
    waitv(3, 5'h02);
    drv.request_line <= 4'h0;
    wait_state(3'h0);
    rd(ADDR_STATUS, r);
    chk("success", 32'h1, {24'h0, r[31:24]});
  endtask : s_seq
  task automatic s_crit();
    setup(32'h1);
    drv.critical_request <= 1'b1;
    repeat (20) @(posedge clk);
    chk("idle_crit", 32'h0, {27'h0, final_trip});
    drv.critical_request <= 1'b0;
    drv.request_line <= 4'h1;
    waitv(0, 5'h01);
    drv.request_line <= 4'h0;
    waitv(1, 5'h01);
    waitv(1, 5'h00);
    drv.critical_request <= 1'b1;
    waitv(4, 5'h10);
    drv.critical_request <= 1'b0;
    wait_state(3'h5);
    waitv(4, 5'h00);
    mclose();
    wait_state(3'h7);
    drv.request_line <= 4'h1;
    repeat (20) @(posedge clk);
    chk("ignored", 32'h0, {31'h0, open_cmd});
    drv.request_line <= 4'h0;
    wait_state(3'h0);
  endtask : s_crit
  task automatic s_noline();
    setup(32'h0);
    drv.request_line <= 4'h4;
    waitv(4, 5'h04);
    drv.request_line <= 4'h0;
    waitv(4, 5'h00);
    mclose();
    wait_state(3'h0);
  endtask : s_noline
  task automatic s_block();
    setup(32'h11);
    drv.shot_block <= 5'h01;
    drv.request_line <= 4'h1;
    waitv(3, 5'h02);
    drv.request_line <= 4'h0;
    wait_state(3'h0);
    drv.shot_block <= 5'h00;
  endtask : s_block
  task automatic s_stop(input int k);
    setup(32'h1);
    drv.request_line <= 4'h1;
    waitv(2, 5'h01);
    drv.request_line <= 4'h0;
    drv.manual_open <= (k == 0);
    drv.control_fail <= (k == 1);
    drv.external_control <= (k == 2);
    wait_state(3'h0);
    repeat (20) @(posedge clk);
    chk("reclosed", 32'h0, {31'h0, close_cmd | b1});
    drv.manual_open <= 1'b0;
    drv.control_fail <= 1'b0;
    drv.external_control <= 1'b0;
    mclose();
    wait_state(3'h0);
  endtask : s_stop
  // lines 1 and 2 together, last shot in use blocked: line 1 trips
  task automatic s_last();
    setup(32'h11);
    drv.shot_block <= 5'h02;
    drv.request_line <= 4'h3;
    waitv(4, 5'h01);
    drv.request_line <= 4'h0;
    drv.shot_block <= 5'h00;
    waitv(4, 5'h00);
    mclose();
    wait_state(3'h0);
  endtask : s_last
  // leaves the second breaker in control, so it runs last
  task automatic s_second();
    logic [31:0] r;
    setup(32'h1);
    wr(ADDR_CTRL, 32'h103);
    drv.alternate_breaker_select_input <= 1'b1;
    repeat (20) @(posedge clk);
    chk("held_object", 32'h0, {28'h0, ctrl_object});
    drv.request_line <= 4'h1;
    waitv(0, 5'h01);
    drv.request_line <= 4'h0;
    waitv(1, 5'h01);
    chk("second_object", 32'h1, {28'h0, ctrl_object});
    waitv(1, 5'h00);
    repeat (90) @(posedge clk);
    chk("shot_reclaim", 32'h0, {27'h0, shot_active});
    rd(ADDR_STATUS, r);
    chk("second_sel", 32'h1, {31'h0, r[20]});
  endtask : s_second
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    s_regs();
    s_seq();
    s_crit();
    s_noline();
    s_block();
    s_last();
    s_stop(0);
    s_stop(1);
    s_stop(2);
    s_second();
    final_report();
  end
endmodule : arseq_top_bench
bind arseq_top arseq_chk #(.TICK_DIV(TICK_DIV)) chk_i (.clk(clk),
  .rst_n(rst_n), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .open_cmd(open_cmd),
  .close_cmd(close_cmd), .dead_running(dead_running),
  .shot_active(shot_active), .final_trip(final_trip));
